// ===== design/privileged_system_function_decode.sv
`timescale 1ns/10ps
module privileged_system_function_decode
    import system_function_pkg::*;
(
    // clock and initialize
    input wire logic clk,
    input wire logic rst_n,
    // instruction issue
    input wire logic instValid,
    input wire logic [7:0] instOpcode,
    input wire logic [3:0] instSubCode,
    input wire logic [system_function_pkg::ADDR_W-1:0] operandAddr,
    input wire logic privilegedState,
    input wire logic [0:system_function_pkg::PSW_W-1] programStatusWord,
    // fullword memory read
    output logic memReadReq,
    output logic [system_function_pkg::ADDR_W-1:0] memReadAddr,
    input wire logic [system_function_pkg::DATA_W-1:0] memReadData,
    input wire logic memReadValid,
    // translator state
    output logic [system_function_pkg::DATA_W-1:0] sharedTableDescriptor,
    output logic [system_function_pkg::DATA_W-1:0] processTableDescriptor,
    output logic translationEnable,
    // completion and dispatch
    output logic busy,
    output logic instDone,
    output logic privilegeViolation,
    output logic condCodeWrite,
    output logic [system_function_pkg::NUM_FUNCS-1:0] functionStart
);
    import system_function_pkg::*;

    state_type q, d;
    logic [NUM_FUNCS-1:0] hit;
    logic issue;
    logic sharedReturn;
    logic processReturn;

    system_function_decoder i_system_function_decoder (
        .opcode(instOpcode),
        .subCode(instSubCode),
        .hit(hit)
    );

    assign issue = instValid && (instOpcode == OPC_SYSTEM_FUNCTION) && (q.phase == PH_IDLE);
    assign sharedReturn = (q.phase == PH_WAIT_SHARED) && memReadValid;
    assign processReturn = (q.phase == PH_WAIT_PROCESS) && memReadValid;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.violation = 1'b0;
        d.start = '0;
        d.ccWrite = 1'b0;
        case (q.phase)
            PH_IDLE: begin
                if (issue) begin
                    if (!privilegedState) begin
                        // suppressed, nothing loaded
                        d.violation = 1'b1;
                        d.done = 1'b1;
                    end else if (hit[FN_LOAD_SHARED_TABLE]) begin
                        // accepted whatever bit 21 holds
                        d.memReq = 1'b1;
                        d.busy = 1'b1;
                        d.memAddr = {operandAddr[ADDR_W-1:2], FULLWORD_LOW_BITS};
                        d.phase = PH_WAIT_SHARED;
                    end else if (hit[FN_LOAD_PROCESS_TABLE]) begin
                        d.memReq = 1'b1;
                        d.busy = 1'b1;
                        d.memAddr = {operandAddr[ADDR_W-1:2], FULLWORD_LOW_BITS};
                        d.phase = PH_WAIT_PROCESS;
                    end else begin
                        // handed to the owning units
                        d.start = hit;
                        d.done = 1'b1;
                    end
                end
            end
            PH_WAIT_SHARED: begin
                if (memReadValid) begin
                    d.sharedDesc = memReadData;
                    d.busy = 1'b0;
                    d.memReq = 1'b0;
                    d.done = 1'b1;
                    d.phase = PH_IDLE;
                end
            end
            PH_WAIT_PROCESS: begin
                if (memReadValid) begin
                    d.processDesc = memReadData;
                    d.busy = 1'b0;
                    d.translateEn = programStatusWord[PSW_TRANSLATE_BIT];
                    d.memReq = 1'b0;
                    d.done = 1'b1;
                    d.phase = PH_IDLE;
                end
            end
            default: begin
                d.phase = PH_IDLE;
                d.busy = 1'b0;
                d.memReq = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.phase <= PH_IDLE;
            q.busy <= 1'b0;
            q.sharedDesc <= DESC_RESET;
            q.processDesc <= DESC_RESET;
            q.translateEn <= 1'b0;
            q.memReq <= 1'b0;
            q.memAddr <= '0;
            q.done <= 1'b0;
            q.violation <= 1'b0;
            q.ccWrite <= 1'b0;
            q.start <= '0;
        end else begin
            q <= d;
        end
    end

    assign memReadReq = q.memReq;
    assign memReadAddr = q.memAddr;
    assign sharedTableDescriptor = q.sharedDesc;
    assign processTableDescriptor = q.processDesc;
    assign translationEnable = q.translateEn;
    assign busy = q.busy;
    assign instDone = q.done;
    assign privilegeViolation = q.violation;
    assign condCodeWrite = q.ccWrite;
    assign functionStart = q.start;

    // checks
    sequence unprivIssue_s;
        issue && !privilegedState;
    endsequence

    sequence sharedIssue_s;
        issue && privilegedState && hit[FN_LOAD_SHARED_TABLE];
    endsequence

    sequence processIssue_s;
        issue && privilegedState && hit[FN_LOAD_PROCESS_TABLE];
    endsequence

    sequence sharedReturn_s;
        sharedReturn;
    endsequence

    sequence processReturn_s;
        processReturn;
    endsequence

    unpriv_suppress_a: assert property (@(posedge clk) disable iff (!rst_n)
        unprivIssue_s |=> privilegeViolation && instDone && !memReadReq && $stable(sharedTableDescriptor))
        else $error("unprivileged function not suppressed");

    shared_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
        sharedIssue_s |=> memReadReq && busy && memReadAddr[1:0] == FULLWORD_LOW_BITS)
        else $error("shared load did not fetch");

    shared_any_bit21_a: assert property (@(posedge clk) disable iff (!rst_n)
        sharedIssue_s ##0 programStatusWord[PSW_TRANSLATE_BIT] |=> !privilegeViolation && memReadReq)
        else $error("shared load refused with bit 21 set");

    shared_install_a: assert property (@(posedge clk) disable iff (!rst_n)
        sharedReturn_s |=> sharedTableDescriptor == $past(memReadData) && instDone && !memReadReq)
        else $error("shared descriptor not installed");

    shared_cc_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
        sharedReturn_s |=> instDone ##0 !condCodeWrite ##1 !condCodeWrite)
        else $error("condition code touched by shared load");

    process_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
        processIssue_s |=> memReadReq && busy && !instDone && memReadAddr[1:0] == FULLWORD_LOW_BITS)
        else $error("process load did not fetch");

    translate_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        processReturn_s |=> translationEnable == $past(programStatusWord[PSW_TRANSLATE_BIT]))
        else $error("translation enable not taken from bit 21");

    translate_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(translationEnable) |-> $past(processReturn))
        else $error("translation enable changed without process load");

    dispatch_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue && privilegedState && !(|(hit & LOCAL_FUNCS_MASK))
        |=> functionStart == $past(hit) && instDone ##1 (functionStart == '0 || $past(issue)))
        else $error("function dispatch wrong");

    dispatch_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue && privilegedState && hit[FN_STORE_BYTE_NO_CHECK] |=> functionStart[FN_STORE_BYTE_NO_CHECK])
        else $error("byte store not dispatched");

    dispatch_logger_a: assert property (@(posedge clk) disable iff (!rst_n)
        issue && privilegedState && (hit[FN_CLEAR_VOLTAGE_FAIL] || hit[FN_READ_ERROR_LOGGER])
        |=> $onehot(functionStart) && !busy)
        else $error("voltage or logger function not dispatched");

    process_install_a: assert property (@(posedge clk) disable iff (!rst_n)
        processReturn_s |=> processTableDescriptor == $past(memReadData) && instDone && !memReadReq && !busy)
        else $error("process descriptor not installed");

    shared_bit21_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        sharedIssue_s ##0 !programStatusWord[PSW_TRANSLATE_BIT] |=> !privilegeViolation && memReadReq)
        else $error("shared load refused with bit 21 clear");

    shared_keeps_translate_a: assert property (@(posedge clk) disable iff (!rst_n)
        sharedReturn_s |=> $stable(translationEnable) && $stable(processTableDescriptor))
        else $error("shared load touched process state");

    local_not_dispatched_a: assert property (@(posedge clk) disable iff (!rst_n)
        !functionStart[FN_LOAD_PROCESS_TABLE] && !functionStart[FN_LOAD_SHARED_TABLE])
        else $error("descriptor load handed out");

    shared_wait_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.phase == PH_WAIT_SHARED && !memReadValid
        |=> memReadReq && busy && !instDone && $stable(memReadAddr) && $stable(sharedTableDescriptor))
        else $error("shared fetch not held");

    busy_refuses_a: assert property (@(posedge clk) disable iff (!rst_n)
        busy && !memReadValid |=> !privilegeViolation && functionStart == '0)
        else $error("offer taken while busy");

    unpriv_no_dispatch_a: assert property (@(posedge clk) disable iff (!rst_n)
        unprivIssue_s |=> functionStart == '0 && !busy
            && $stable(processTableDescriptor) && $stable(translationEnable))
        else $error("unprivileged function acted on");

    violation_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        privilegeViolation |-> instDone && functionStart == '0)
        else $error("violation without completion");
endmodule : privileged_system_function_decode

// ===== shared/system_function_pkg.sv
// What this block does
// - shared descriptor load installs fullword shared table
// - shared descriptor load needs privileged state
// - shared load accepted with bit 21 either way
// - code one loads process table descriptor
// - code two loads shared table descriptor
// - codes three to six: process, interruptible state
// - code seven stores byte without check bits
// - code eight clears voltage failure; zero reads logger
// - translation off until process descriptor load
// - initialize disables all translation functions
package system_function_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int PSW_W = 32;
    localparam int NUM_FUNCS = 9;
    localparam int PSW_TRANSLATE_BIT = 21;
    localparam logic [7:0] OPC_SYSTEM_FUNCTION = 8'hDF;
    localparam logic [3:0] FN_READ_ERROR_LOGGER = 4'h0;
    localparam logic [3:0] FN_LOAD_PROCESS_TABLE = 4'h1;
    localparam logic [3:0] FN_LOAD_SHARED_TABLE = 4'h2;
    localparam logic [3:0] FN_SAVE_PROCESS_STATE = 4'h3;
    localparam logic [3:0] FN_LOAD_PROCESS_STATE = 4'h4;
    localparam logic [3:0] FN_SAVE_INTR_STATE = 4'h5;
    localparam logic [3:0] FN_RESTORE_INTR_STATE = 4'h6;
    localparam logic [3:0] FN_STORE_BYTE_NO_CHECK = 4'h7;
    localparam logic [3:0] FN_CLEAR_VOLTAGE_FAIL = 4'h8;
    localparam logic [1:0] FULLWORD_LOW_BITS = 2'h0;
    localparam logic [DATA_W-1:0] DESC_RESET = 32'h00000000;
    localparam logic [NUM_FUNCS-1:0] LOCAL_FUNCS_MASK = 9'h006;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WAIT_SHARED,
        PH_WAIT_PROCESS
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic busy;
        logic [DATA_W-1:0] sharedDesc;
        logic [DATA_W-1:0] processDesc;
        logic translateEn;
        logic memReq;
        logic [ADDR_W-1:0] memAddr;
        logic done;
        logic violation;
        logic ccWrite;
        logic [NUM_FUNCS-1:0] start;
    } state_type;
endpackage : system_function_pkg

// ===== design/system_function_decoder.sv
`timescale 1ns/10ps
module system_function_decoder
    import system_function_pkg::*;
(
    // instruction fields
    input wire logic [7:0] opcode,
    input wire logic [3:0] subCode,
    // one-hot function select
    output logic [NUM_FUNCS-1:0] hit
);
    genvar i;
    generate
        for (i = 0; i < NUM_FUNCS; i++) begin : g_fn
            assign hit[i] = (opcode == OPC_SYSTEM_FUNCTION) && (subCode == 4'(i));
        end
    endgenerate
endmodule : system_function_decoder

// ===== verif/test_privileged_system_function_decode.sv
`timescale 1ns/10ps
module test_privileged_system_function_decode;
    import system_function_pkg::*;
    typedef struct packed {
        logic viol;
        logic [NUM_FUNCS-1:0] start;
        logic [DATA_W-1:0] shared;
        logic [DATA_W-1:0] process;
        logic trans;
    } note_type;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instValid = 1'b0;
    logic [7:0] instOpcode = 8'h00;
    logic [3:0] instSubCode = 4'h0;
    logic [ADDR_W-1:0] operandAddr = '0;
    logic privilegedState = 1'b0;
    logic [0:PSW_W-1] programStatusWord = '0;
    logic [DATA_W-1:0] memReadData = '0;
    logic memReadValid = 1'b0;
    logic memReadReq, translationEnable, busy, instDone, privilegeViolation, condCodeWrite;
    logic [ADDR_W-1:0] memReadAddr;
    logic [DATA_W-1:0] sharedTableDescriptor, processTableDescriptor;
    logic [NUM_FUNCS-1:0] functionStart;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 32'hACF873E5;
    note_type notes[$];
    note_type seen;
    logic [DATA_W-1:0] expShared = '0;
    logic [DATA_W-1:0] expProcess = '0;
    logic expTrans = 1'b0;

    privileged_system_function_decode i_privileged_system_function_decode (.clk(clk), .rst_n(rst_n),
        .instValid(instValid), .instOpcode(instOpcode), .instSubCode(instSubCode), .operandAddr(operandAddr),
        .privilegedState(privilegedState), .programStatusWord(programStatusWord), .memReadReq(memReadReq),
        .memReadAddr(memReadAddr), .memReadData(memReadData), .memReadValid(memReadValid),
        .sharedTableDescriptor(sharedTableDescriptor), .processTableDescriptor(processTableDescriptor),
        .translationEnable(translationEnable), .busy(busy), .instDone(instDone),
        .privilegeViolation(privilegeViolation), .condCodeWrite(condCodeWrite), .functionStart(functionStart));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task check_word(input string what, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // offer one instruction, answer its fetch, note the outcome
    task issue(input logic [3:0] sub, input logic [ADDR_W-1:0] addr, input logic priv, input logic bit21);
        logic [DATA_W-1:0] data;
        note_type n;
        data = $random(seed);
        n = '{viol: ~priv, start: '0, shared: expShared, process: expProcess, trans: expTrans};
        if (priv && (sub == 4'h0 || (sub > 4'h2 && sub < 4'h9))) n.start[sub] = 1'b1;
        if (priv && sub == FN_LOAD_SHARED_TABLE) n.shared = data;
        if (priv && sub == FN_LOAD_PROCESS_TABLE) begin
            n.process = data;
            n.trans = bit21;
        end
        expShared = n.shared;
        expProcess = n.process;
        expTrans = n.trans;
        notes.push_back(n);
        @(posedge clk);
        instValid <= 1'b1;
        instOpcode <= OPC_SYSTEM_FUNCTION;
        instSubCode <= sub;
        operandAddr <= {addr[ADDR_W-1:2], 2'b00};
        privilegedState <= priv;
        programStatusWord[PSW_TRANSLATE_BIT] <= bit21;
        if (priv && (sub == FN_LOAD_SHARED_TABLE || sub == FN_LOAD_PROCESS_TABLE)) begin
            @(posedge clk);
            instValid <= 1'b0;
            #1;
            check_word("fetch request", DATA_W'(memReadReq), 1);
            check_word("fetch address", DATA_W'(memReadAddr), DATA_W'({addr[ADDR_W-1:2], 2'b00}));
            check_word("busy", DATA_W'(busy), 1);
            repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk);
            memReadValid <= 1'b1;
            memReadData <= data;
            @(posedge clk);
            memReadValid <= 1'b0;
            memReadData <= ~data;
            @(posedge clk);
        end
    endtask : issue

    // completion watcher
    always @(negedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            err_count++;
            report_and_stop;
        end else if (rst_n === 1'b1 && instDone === 1'b1) begin
            if (notes.size() == 0) begin
                check_word("unexpected completion", 1, 0);
            end else begin
                seen = notes.pop_front();
                check_word("violation", DATA_W'(privilegeViolation), DATA_W'(seen.viol));
                check_word("dispatch", DATA_W'(functionStart), DATA_W'(seen.start));
                check_word("shared descriptor", sharedTableDescriptor, seen.shared);
                check_word("process descriptor", processTableDescriptor, seen.process);
                check_word("translate", DATA_W'(translationEnable), DATA_W'(seen.trans));
                check_word("cc write", DATA_W'(condCodeWrite), 0);
                check_word("busy at done", DATA_W'(busy), 0);
            end
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        issue(FN_LOAD_SHARED_TABLE, 24'h000103, 1'b1, 1'b1);
        issue(FN_LOAD_SHARED_TABLE, ADDR_W'($random(seed)), 1'b1, 1'b0);
        issue(FN_LOAD_PROCESS_TABLE, ADDR_W'($random(seed)), 1'b1, 1'b1);
        issue(FN_LOAD_PROCESS_TABLE, ADDR_W'($random(seed)), 1'b1, 1'b0);
        for (int k = 0; k < 16; k++) issue(k[3:0], ADDR_W'($random(seed)), 1'b1, k[0]);
        for (int k = 0; k < 9; k++) issue(k[3:0], ADDR_W'($random(seed)), 1'b0, 1'b1);
        @(posedge clk);
        instValid <= 1'b0;
        repeat (4) @(posedge clk);
        check_word("pending notes", notes.size(), 0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_word("shared after init", sharedTableDescriptor, 0);
        check_word("translate after init", DATA_W'(translationEnable), 0);
        expShared = '0;
        expProcess = '0;
        expTrans = 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        issue(FN_LOAD_SHARED_TABLE, ADDR_W'($random(seed)), 1'b1, 1'b1);
        issue(FN_LOAD_PROCESS_TABLE, ADDR_W'($random(seed)), 1'b1, 1'b1);
        repeat (4) @(posedge clk);
        report_and_stop;
    end
endmodule : test_privileged_system_function_decode
